// ===== power_mode_pkg.sv
// Constants, register map and mode enumeration of the power mode controller.
// Assumes an 8-bit register port and a single 40 MHz core clock.
package power_mode_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] ADDR_CRYSTAL = 3'h0;
  localparam logic [2:0] ADDR_POWER = 3'h1;
  localparam logic [2:0] ADDR_CLOCK = 3'h2;
  localparam logic [2:0] ADDR_PORT_WAKE = 3'h3;
  localparam logic [2:0] ADDR_STATUS = 3'h4;

  // crystal_osc_control fields
  localparam int XTAL_EN_BIT = 0;
  localparam int XTAL_STABLE_BIT = 1;
  localparam logic [7:0] XTAL_RESET = 8'h00;

  // power_control fields
  localparam int PWR_DEEP_BIT = 0;
  localparam int PWR_ISO_BIT = 1;
  localparam int PWR_LCM_BIT = 2;
  localparam int PWR_POR33_BIT = 3;
  localparam int PWR_TB_WAKE_BIT = 4;
  localparam int PWR_TOUCH_WAKE_FLAG_BIT = 6;
  localparam int PWR_PORT_WAKE_FLAG_BIT = 7;
  localparam logic [7:0] PWR_RESET = 8'h08;
  localparam logic [7:0] PWR_IMPL_MASK = 8'hDF;

  // system_clock_control_register fields
  localparam int CLK_SLOW_HALT_BIT = 0;
  localparam int CLK_FAST_HALT_BIT = 1;
  localparam int CLK_SEL_LSB = 5;
  localparam logic [7:0] CLK_RESET = 8'h20;
  localparam logic [7:0] CLK_IMPL_MASK = 8'hEF;
  localparam logic [2:0] CLK_SEL_SUB = 3'h7;

  // port_wake_enable_register
  localparam logic [7:0] PORT_WAKE_RESET = 8'h00;

  // Status register fields
  localparam int STAT_PDF_BIT = 4;
  localparam int STAT_TO_BIT = 5;
  localparam int STAT_INTERNAL_SLOW_RC_BIT = 6;

  // Restart vector handed to the core after a deep sleep wake
  localparam logic [15:0] RESTART_VECTOR = 16'h0000;

  typedef enum logic [2:0] {
    MODE_FAST,
    MODE_SLOW,
    MODE_SLEEP,
    MODE_IDLE0,
    MODE_IDLE1,
    MODE_IDLE2,
    MODE_DEEP
  } mode_e;

endpackage : power_mode_pkg

// ===== power_mode_controller.sv
// Power mode controller: oscillator control, deep sleep power register,
// HALT mode decision, wake handling and I/O isolation latch.
// Assumes core strobes (halt, clear-watchdog, interrupts, time base, touch)
// are on core_clk; oscillator ready levels and port pins are asynchronous.
//
// Behaviour
// RULE_01: Stable flag clears on oscillator enable, sets once oscillator is stable; read-only.
// RULE_02: Writable crystal enable bit, resets 0, upper bits read zero.
// RULE_03: Port wake flag set when enabled port falling edge wakes deep sleep.
// RULE_04: Touch wake flag set when touch key wakes deep sleep.
// RULE_05: Timebase wake flag set when time base zero wakes deep sleep.
// RULE_06: Firmware configures wake sources and clears wake flags before deep sleep.
// RULE_07: Domain power-on flag set by hardware, resets 1, cleared by write or watchdog clear.
// RULE_08: Regulator mode bit selects normal (0) or low-current (1) regulator.
// RULE_09: Isolation bit holds port pins latched; firmware sets before sleep, clears after.
// RULE_10: HALT with deep sleep bit set enters deep sleep, regulator off.
// RULE_11: Data memory keeps its contents through deep sleep.
// RULE_12: Deep sleep entry clears the radio power enable bit.
// RULE_13: Deep sleep wakes on port edge, touch or time base, restarts at zero.
// RULE_14: Time base zero wakes deep sleep even with its interrupt disabled.
// RULE_15: In deep sleep time base zero runs from the slow internal oscillator.
// RULE_16: Deep sleep wake resets registers to power-on values; the status power-down and timeout flags keep their values.
// RULE_17: Clock select all ones switches system clock to the sub clock.
// RULE_18: Switch to slow mode completes only once the slow oscillator is stable.
// RULE_19: Select values zero to six give fast clock divided 1 to 64.
// RULE_20: HALT with deep bit and both halt enables 0 enters sleep, clock stops.
// RULE_21: HALT with fast halt 0, slow halt 1 enters idle0, sub clock kept.
// RULE_22: Sleep or idle entry sets power-down flag, clears timeout, clears watchdog.
// RULE_23: Halt enable bits decide which oscillators run while the core is halted.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module power_mode_controller #(
  parameter int PORT_W = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic halt_exec,
  input wire logic clr_wdt_exec,
  input wire logic wdt_timeout,
  input wire logic irq_wake,
  input wire logic touch_event,
  input wire logic timebase_tick,
  input wire logic crystal_ready,
  input wire logic slow_rc_ready,
  input wire logic domain33_por,
  input wire logic [PORT_W-1:0] port_pins,
  input wire logic [PORT_W-1:0] port_out_live,
  output logic [PORT_W-1:0] port_out_held,
  output logic crystal_osc_enable,
  output logic regulator_low_current_sel,
  output logic regulator_off,
  output logic io_isolate,
  output logic [2:0] system_clock_select,
  output logic sys_clk_use_sub,
  output logic cpu_clk_stop,
  output logic fast_osc_run,
  output logic slow_osc_run,
  output logic timebase_from_slow_rc,
  output logic ram_retain,
  output logic radio_power_clear,
  output logic cpu_restart,
  output logic [15:0] restart_addr,
  output logic periph_reinit,
  output logic wdt_clear,
  output logic power_down_flag,
  output logic watchdog_timeout_flag
);

  // True for the two running modes
  function automatic logic is_run(input power_mode_pkg::mode_e m);
    is_run = (m == power_mode_pkg::MODE_FAST) || (m == power_mode_pkg::MODE_SLOW);
  endfunction : is_run

  // Mode chosen by HALT from the deep bit and the two halt enables
  function automatic power_mode_pkg::mode_e halt_target(input logic deep, input logic fh,
                                                        input logic fs);
    if (deep) begin
      halt_target = power_mode_pkg::MODE_DEEP;
    end else if (fh && fs) begin
      halt_target = power_mode_pkg::MODE_IDLE1;
    end else if (fh) begin
      halt_target = power_mode_pkg::MODE_IDLE2;
    end else if (fs) begin
      halt_target = power_mode_pkg::MODE_IDLE0;
    end else begin
      halt_target = power_mode_pkg::MODE_SLEEP;
    end
  endfunction : halt_target

  // Synchronisers for asynchronous levels; stage one feeds stage two only
  logic xtal_rdy_s1_q, xtal_rdy_s2_q;
  logic internal_slow_rc_s1_q, internal_slow_rc_s2_q;
  logic por33_s1_q, por33_s2_q, por33_prev_q;
  logic [PORT_W-1:0] pins_s1_q, pins_s2_q, pins_prev_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      xtal_rdy_s1_q <= 1'b0;
      xtal_rdy_s2_q <= 1'b0;
      internal_slow_rc_s1_q <= 1'b0;
      internal_slow_rc_s2_q <= 1'b0;
      por33_s1_q <= 1'b0;
      por33_s2_q <= 1'b0;
      por33_prev_q <= 1'b0;
      pins_s1_q <= '1;
      pins_s2_q <= '1;
      pins_prev_q <= '1;
    end else begin
      xtal_rdy_s1_q <= crystal_ready;
      xtal_rdy_s2_q <= xtal_rdy_s1_q;
      internal_slow_rc_s1_q <= slow_rc_ready;
      internal_slow_rc_s2_q <= internal_slow_rc_s1_q;
      por33_s1_q <= domain33_por;
      por33_s2_q <= por33_s1_q;
      por33_prev_q <= por33_s2_q;
      pins_s1_q <= port_pins;
      pins_s2_q <= pins_s1_q;
      pins_prev_q <= pins_s2_q;
    end
  end

  // Registers and state
  logic [7:0] xtal_q, pwr_q, clk_q, port_wake_enable_register_q;
  power_mode_pkg::mode_e mode_q, mode_d;
  logic pdf_q, to_q;

  // Register port decode
  wire wr_xtal = reg_wr && (reg_addr == power_mode_pkg::ADDR_CRYSTAL);
  wire wr_pwr = reg_wr && (reg_addr == power_mode_pkg::ADDR_POWER);
  wire wr_clk = reg_wr && (reg_addr == power_mode_pkg::ADDR_CLOCK);
  wire wr_port_wake_enable_register = reg_wr && (reg_addr == power_mode_pkg::ADDR_PORT_WAKE);

  // Wake and HALT decode
  wire in_deep = (mode_q == power_mode_pkg::MODE_DEEP);
  wire in_run = is_run(mode_q);
  wire port_fall_any = |(pins_prev_q & ~pins_s2_q & port_wake_enable_register_q);
  wire deep_port_wake = in_deep && port_fall_any; // see RULE_03
  wire deep_touch_wake = in_deep && touch_event; // see RULE_04
  wire deep_tb_wake = in_deep && timebase_tick; // see RULE_05 see RULE_14
  wire deep_wake = deep_port_wake || deep_touch_wake || deep_tb_wake; // see RULE_13
  wire halt_wake = !in_run && !in_deep && (port_fall_any || irq_wake || wdt_timeout);
  wire halt_go = in_run && halt_exec;
  wire por33_rise = por33_s2_q && !por33_prev_q;
  wire [2:0] clk_sel = clk_q[power_mode_pkg::CLK_SEL_LSB +: 3];
  wire want_sub = (clk_sel == power_mode_pkg::CLK_SEL_SUB); // see RULE_17
  wire xtal_turn_on = wr_xtal && reg_wdata[power_mode_pkg::XTAL_EN_BIT] &&
                      !xtal_q[power_mode_pkg::XTAL_EN_BIT];

  // Next mode; slow mode is only reached once the slow RC is stable
  always_comb begin
    mode_d = mode_q;
    if (halt_go) begin
      mode_d = halt_target(pwr_q[power_mode_pkg::PWR_DEEP_BIT], // see RULE_10 see RULE_20
                           clk_q[power_mode_pkg::CLK_FAST_HALT_BIT], // see RULE_21
                           clk_q[power_mode_pkg::CLK_SLOW_HALT_BIT]);
    end else if (deep_wake) begin
      mode_d = power_mode_pkg::MODE_FAST; // Clock select resets to a fast divide
    end else if (halt_wake || in_run) begin
      mode_d = (want_sub && internal_slow_rc_s2_q) ? power_mode_pkg::MODE_SLOW // see RULE_18
                                        : power_mode_pkg::MODE_FAST; // see RULE_19
    end
  end

  // Crystal control: stable flag drops on enable and returns with the ready level
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      xtal_q <= power_mode_pkg::XTAL_RESET;
    end else if (deep_wake) begin
      xtal_q <= power_mode_pkg::XTAL_RESET; // see RULE_16
    end else begin
      if (wr_xtal) begin
        xtal_q[power_mode_pkg::XTAL_EN_BIT] <= reg_wdata[power_mode_pkg::XTAL_EN_BIT]; // see RULE_02
      end
      if (xtal_turn_on || !xtal_q[power_mode_pkg::XTAL_EN_BIT]) begin
        xtal_q[power_mode_pkg::XTAL_STABLE_BIT] <= 1'b0; // see RULE_01
      end else if (xtal_rdy_s2_q) begin
        xtal_q[power_mode_pkg::XTAL_STABLE_BIT] <= 1'b1; // see RULE_01
      end
    end
  end

  // Power register: hardware sets win over a software clear in the same cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pwr_q <= power_mode_pkg::PWR_RESET;
    end else if (deep_wake) begin
      // Everything returns to power-on values except what records the wake
      pwr_q <= power_mode_pkg::PWR_RESET; // see RULE_16
      pwr_q[power_mode_pkg::PWR_PORT_WAKE_FLAG_BIT] <= deep_port_wake; // see RULE_03
      pwr_q[power_mode_pkg::PWR_TOUCH_WAKE_FLAG_BIT] <= deep_touch_wake; // see RULE_04
      pwr_q[power_mode_pkg::PWR_TB_WAKE_BIT] <= deep_tb_wake; // see RULE_05
    end else begin
      if (wr_pwr) begin
        pwr_q <= reg_wdata & power_mode_pkg::PWR_IMPL_MASK; // see RULE_08 see RULE_09
      end
      if (clr_wdt_exec) begin
        pwr_q[power_mode_pkg::PWR_POR33_BIT] <= 1'b0; // see RULE_07
      end
      if (por33_rise) begin
        pwr_q[power_mode_pkg::PWR_POR33_BIT] <= 1'b1; // see RULE_07
      end
    end
  end

  // Clock select and port wake enables
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clk_q <= power_mode_pkg::CLK_RESET;
      port_wake_enable_register_q <= power_mode_pkg::PORT_WAKE_RESET;
    end else if (deep_wake) begin
      clk_q <= power_mode_pkg::CLK_RESET; // see RULE_16
      port_wake_enable_register_q <= power_mode_pkg::PORT_WAKE_RESET;
    end else begin
      if (wr_clk) begin
        clk_q <= reg_wdata & power_mode_pkg::CLK_IMPL_MASK;
      end
      if (wr_port_wake_enable_register) begin
        port_wake_enable_register_q <= reg_wdata;
      end
    end
  end

  // Mode, power-down and timeout flags
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= power_mode_pkg::MODE_FAST;
      pdf_q <= 1'b0;
      to_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      if (halt_go) begin
        pdf_q <= 1'b1; // see RULE_22
        to_q <= 1'b0; // see RULE_22
      end else begin
        if (clr_wdt_exec) begin
          pdf_q <= 1'b0;
          to_q <= 1'b0;
        end
        if (wdt_timeout) begin
          to_q <= 1'b1; // Timeout wins over a clear in the same cycle
        end
      end
    end
  end

  // Read data, one cycle after the read strobe; unmapped reads give zero
  logic [7:0] rd_mux;
  wire [7:0] status_word = {1'b0, internal_slow_rc_s2_q, to_q, pdf_q, 1'b0, 3'(mode_q)};
  always_comb begin
    case (reg_addr)
      power_mode_pkg::ADDR_CRYSTAL: rd_mux = xtal_q;
      power_mode_pkg::ADDR_POWER: rd_mux = pwr_q;
      power_mode_pkg::ADDR_CLOCK: rd_mux = clk_q;
      power_mode_pkg::ADDR_PORT_WAKE: rd_mux = port_wake_enable_register_q;
      power_mode_pkg::ADDR_STATUS: rd_mux = status_word;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Output decode from the next state so every output is a flop
  wire iso_d = pwr_q[power_mode_pkg::PWR_ISO_BIT];
  wire halted_d = !is_run(mode_d);
  wire deep_d = (mode_d == power_mode_pkg::MODE_DEEP);
  wire fast_run_d = is_run(mode_d) || (mode_d == power_mode_pkg::MODE_IDLE1) ||
                    (mode_d == power_mode_pkg::MODE_IDLE2); // see RULE_23
  wire slow_run_d = is_run(mode_d) || (mode_d == power_mode_pkg::MODE_IDLE0) ||
                    (mode_d == power_mode_pkg::MODE_IDLE1); // see RULE_23

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      crystal_osc_enable <= 1'b0;
      regulator_low_current_sel <= 1'b0;
      regulator_off <= 1'b0;
      io_isolate <= 1'b0;
      system_clock_select <= power_mode_pkg::CLK_RESET[power_mode_pkg::CLK_SEL_LSB +: 3];
      sys_clk_use_sub <= 1'b0;
      cpu_clk_stop <= 1'b0;
      fast_osc_run <= 1'b1;
      slow_osc_run <= 1'b1;
      timebase_from_slow_rc <= 1'b0;
      ram_retain <= 1'b0;
    end else begin
      // Crystal is forced off in deep sleep whatever its enable says
      crystal_osc_enable <= xtal_q[power_mode_pkg::XTAL_EN_BIT] && !deep_d;
      regulator_low_current_sel <= pwr_q[power_mode_pkg::PWR_LCM_BIT]; // see RULE_08
      regulator_off <= deep_d; // see RULE_10
      io_isolate <= iso_d; // see RULE_09
      system_clock_select <= clk_sel; // see RULE_19
      sys_clk_use_sub <= (mode_d == power_mode_pkg::MODE_SLOW); // see RULE_17 see RULE_18
      cpu_clk_stop <= halted_d; // see RULE_20
      fast_osc_run <= fast_run_d;
      slow_osc_run <= slow_run_d; // see RULE_21
      timebase_from_slow_rc <= deep_d; // see RULE_15
      ram_retain <= halted_d; // see RULE_11
    end
  end

  // Port hold latch: follows live values until isolation, then freezes them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      port_out_held <= '0;
    end else if (!iso_d) begin
      port_out_held <= port_out_live;
    end
  end

  // One-cycle event outputs, restart vector and registered power-down and timeout flags
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      radio_power_clear <= 1'b0;
      cpu_restart <= 1'b0;
      restart_addr <= power_mode_pkg::RESTART_VECTOR;
      periph_reinit <= 1'b0;
      wdt_clear <= 1'b0;
      power_down_flag <= 1'b0;
      watchdog_timeout_flag <= 1'b0;
    end else begin
      radio_power_clear <= halt_go && pwr_q[power_mode_pkg::PWR_DEEP_BIT]; // see RULE_12
      cpu_restart <= deep_wake; // see RULE_13
      restart_addr <= power_mode_pkg::RESTART_VECTOR;
      periph_reinit <= deep_wake; // see RULE_16
      wdt_clear <= halt_go; // see RULE_22
      power_down_flag <= pdf_q;
      watchdog_timeout_flag <= to_q;
    end
  end

  // Checks
  a_xtal_flag_drop: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_01
    xtal_turn_on |=> !xtal_q[power_mode_pkg::XTAL_STABLE_BIT])
    else $error("stable flag not cleared on enable");

  a_deep_entry_regoff: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_10
    halt_go && pwr_q[power_mode_pkg::PWR_DEEP_BIT] |=> in_deep ##1 regulator_off)
    else $error("deep sleep entry did not turn regulator off");

  a_radio_clear_deep: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_12
    $rose(in_deep) |-> radio_power_clear)
    else $error("radio power not cleared on deep sleep");

  a_port_wake_flag: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_03
    deep_port_wake |=> pwr_q[power_mode_pkg::PWR_PORT_WAKE_FLAG_BIT] && cpu_restart
                       && mode_q == power_mode_pkg::MODE_FAST)
    else $error("port wake not recorded");

  a_tb_wake_restart: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_14
    deep_tb_wake |=> pwr_q[power_mode_pkg::PWR_TB_WAKE_BIT] ##1 !regulator_off)
    else $error("time base did not wake deep sleep");

  a_por33_set: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_07
    por33_rise |=> pwr_q[power_mode_pkg::PWR_POR33_BIT])
    else $error("domain power-on flag not set");

  a_sleep_entry: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_20
    halt_go && !pwr_q[0] && !clk_q[1] && !clk_q[0] |=> ##1 cpu_clk_stop && !slow_osc_run
      && !fast_osc_run)
    else $error("sleep entry wrong");

  a_idle0_entry: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_21
    halt_go && !pwr_q[0] && !clk_q[1] && clk_q[0] |=> ##1 slow_osc_run && !fast_osc_run)
    else $error("idle0 entry wrong");

  a_halt_flags: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_22
    halt_go |=> pdf_q && !to_q ##1 power_down_flag)
    else $error("power-down flags wrong after halt");

  a_slow_needs_rc: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_18
    sys_clk_use_sub |-> $past(internal_slow_rc_s2_q))
    else $error("slow mode without stable slow oscillator");

  a_iso_hold: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_09
    io_isolate && $past(io_isolate) |-> $stable(port_out_held))
    else $error("port outputs moved while isolated");

endmodule : power_mode_controller

`default_nettype wire

// ===== core_model.sv
// Behavioural model of the processor core facing the power mode controller.
// Assumes the bench calls its tasks just after a rising edge of core_clk.
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic core_clk,
  input wire logic cpu_restart,
  input wire logic [15:0] restart_addr,
  input wire logic wdt_clear,
  input wire logic radio_power_clear,
  output logic halt_exec,
  output logic clr_wdt_exec
);
  int restart_cnt = 0;
  logic [15:0] last_addr = 16'hFFFF;
  logic wdt_seen = 1'b0;
  logic radio_seen = 1'b0;

  initial begin
    halt_exec = 1'b0;
    clr_wdt_exec = 1'b0;
  end

  // Count restarts and keep the vector the core would jump to
  always @(posedge core_clk) begin
    if (cpu_restart === 1'b1) begin
      restart_cnt <= restart_cnt + 1;
      last_addr <= restart_addr;
    end
  end

  // One HALT instruction; the answer pulses stand only in the next cycle
  task automatic do_halt();
    @(posedge core_clk);
    halt_exec <= 1'b1;
    @(posedge core_clk);
    halt_exec <= 1'b0;
    #1 wdt_seen = wdt_clear;
    radio_seen = radio_power_clear;
  endtask : do_halt

  // Clear-watchdog instruction, also clears the domain power-on flag
  task automatic do_clr_wdt();
    @(posedge core_clk);
    clr_wdt_exec <= 1'b1;
    @(posedge core_clk);
    clr_wdt_exec <= 1'b0;
  endtask : do_clr_wdt
endmodule : core_model
`default_nettype wire

// ===== power_mode_controller_tb_top.sv
// Self-checking bench of the power mode controller: registers, modes, halt and wake.
// Assumes a 40 MHz core clock and the core model for HALT and clear-watchdog.
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller_tb_top;
  typedef struct {logic [2:0] a; logic [7:0] w; logic [7:0] r;} row_s;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, wdt_timeout = 1'b0, irq_wake = 1'b0;
  logic touch_event = 1'b0, timebase_tick = 1'b0, crystal_ready = 1'b0;
  logic slow_rc_ready = 1'b0, domain33_por = 1'b0;
  logic [7:0] port_pins = 8'hFF, port_out_live = 8'h00, reg_rdata, port_out_held;
  logic [2:0] system_clock_select;
  logic [15:0] restart_addr;
  logic crystal_osc_enable, regulator_low_current_sel, regulator_off, io_isolate;
  logic sys_clk_use_sub, cpu_clk_stop, fast_osc_run, slow_osc_run, timebase_from_slow_rc;
  logic ram_retain, radio_power_clear, cpu_restart, periph_reinit, wdt_clear;
  logic power_down_flag, watchdog_timeout_flag, halt_exec, clr_wdt_exec;
  int failures = 0, cmp_count = 0, cycles = 0, n0, i, k;
  power_mode_pkg::mode_e modes [4] = '{power_mode_pkg::MODE_SLEEP, power_mode_pkg::MODE_IDLE0,
    power_mode_pkg::MODE_IDLE2, power_mode_pkg::MODE_IDLE1};
  int srcs [3] = '{0, 1, 4};
  logic [7:0] wake_exp [3] = '{8'h18, 8'h48, 8'h88};
  // Write then read back; unmapped and read-only places among them
  row_s rows [9] = '{'{3'h1, 8'h04, 8'h04}, '{3'h1, 8'hFF, 8'hDF}, '{3'h1, 8'h00, 8'h00},
    '{3'h2, 8'hFF, 8'hEF}, '{3'h2, 8'h20, 8'h20}, '{3'h0, 8'hFE, 8'h00},
    '{3'h3, 8'h5A, 8'h5A}, '{3'h4, 8'hFF, 8'h00}, '{3'h7, 8'hFF, 8'h00}};

  power_mode_controller #(.PORT_W(8)) uut (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .halt_exec, .clr_wdt_exec, .wdt_timeout, .irq_wake, .touch_event,
    .timebase_tick, .crystal_ready, .slow_rc_ready, .domain33_por, .port_pins, .port_out_live,
    .port_out_held, .crystal_osc_enable, .regulator_low_current_sel, .regulator_off,
    .io_isolate, .system_clock_select, .sys_clk_use_sub, .cpu_clk_stop, .fast_osc_run,
    .slow_osc_run, .timebase_from_slow_rc, .ram_retain, .radio_power_clear, .cpu_restart,
    .restart_addr, .periph_reinit, .wdt_clear, .power_down_flag, .watchdog_timeout_flag);
  core_model core (.core_clk, .cpu_restart, .restart_addr, .wdt_clear, .radio_power_clear,
    .halt_exec, .clr_wdt_exec);

  // 25 ns period
  always #12.5 core_clk = ~core_clk;

  // Count re-init pulses; each deep wake must give exactly one
  int reinit_cnt = 0;
  always @(posedge core_clk) begin
    if (periph_reinit === 1'b1) begin
      reinit_cnt <= reinit_cnt + 1;
    end
  end

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  // Register port: strobes one cycle, read data only in the cycle after
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(16'(reg_rdata), 16'(e));
  endtask : rd

  // One-cycle event; a port pin falls and stays low until restored
  task automatic pulse(input int which);
    @(posedge core_clk);
    case (which)
      0: timebase_tick <= 1'b1;
      1: touch_event <= 1'b1;
      2: irq_wake <= 1'b1;
      3: wdt_timeout <= 1'b1;
      default: port_pins <= 8'hFE;
    endcase
    @(posedge core_clk);
    {timebase_tick, touch_event, irq_wake, wdt_timeout} <= 4'h0;
  endtask : pulse

  task automatic print_verdict();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    cyc(6);
    nrst <= 1'b1;
    rd(3'h0, 8'h00);
    rd(3'h1, 8'h08);
    rd(3'h2, 8'h20);
    for (i = 0; i < 9; i++) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].r);
    end
    // Crystal: flag low until the oscillator reports stable
    wr(3'h0, 8'h01);
    cyc(1); // The enable pin is one flop behind the register bit
    #1 check(16'(crystal_osc_enable), 16'h0001);
    rd(3'h0, 8'h01);
    crystal_ready <= 1'b1;
    cyc(4);
    rd(3'h0, 8'h03);
    wr(3'h0, 8'h00);
    rd(3'h0, 8'h00);
    // Low-current regulator and isolation latch of the port outputs
    wr(3'h1, 8'h06);
    cyc(1); // Regulator and isolation pins are one flop behind the register
    #1 check(16'({regulator_low_current_sel, io_isolate}), 16'h0003);
    port_out_live <= 8'hA5;
    cyc(3);
    #1 check(16'(port_out_held), 16'h0000);
    wr(3'h1, 8'h00);
    cyc(2);
    #1 check(16'(port_out_held), 16'h00A5);
    // Domain power-on flag: set by hardware, cleared by clear-watchdog
    domain33_por <= 1'b1;
    cyc(4);
    rd(3'h1, 8'h08);
    core.do_clr_wdt();
    rd(3'h1, 8'h00);
    // Slow mode waits for the slow oscillator
    wr(3'h2, 8'hE0);
    cyc(3);
    #1 check(16'(sys_clk_use_sub), 16'h0000);
    slow_rc_ready <= 1'b1;
    cyc(5);
    #1 check(16'(sys_clk_use_sub), 16'h0001);
    rd(3'h4, 8'h41);
    wr(3'h2, 8'h00);
    cyc(3);
    #1 check(16'({sys_clk_use_sub, system_clock_select}), 16'h0000);
    // Each halt-enable pair picks its halted mode
    for (i = 0; i < 4; i++) begin
      wr(3'h2, 8'h20 | 8'(i));
      core.do_halt();
      check(16'(core.wdt_seen), 16'h0001);
      cyc(2);
      #1 check(16'({cpu_clk_stop, fast_osc_run, slow_osc_run}), 16'(4 + i));
      rd(3'h4, 8'h50 | 8'(modes[i]));
      pulse(i == 0 ? 3 : 2);
      cyc(3);
      rd(3'h4, i == 0 ? 8'h70 : 8'h50);
      check(16'({power_down_flag, watchdog_timeout_flag}), i == 0 ? 16'h0003 : 16'h0002);
    end
    core.do_clr_wdt();
    rd(3'h4, 8'h40);
    // Deep sleep through each wake source
    for (i = 0; i < 3; i++) begin
      wr(3'h3, 8'h01);
      wr(3'h1, 8'h03);
      core.do_halt();
      check(16'(core.radio_seen), 16'h0001);
      cyc(2);
      #1 check(16'({regulator_off, timebase_from_slow_rc}), 16'h0003);
      check(16'(ram_retain), 16'h0001);
      check(16'({cpu_clk_stop, fast_osc_run, slow_osc_run}), 16'h0004);
      n0 = core.restart_cnt;
      pulse(2);
      cyc(3);
      #1 check(16'(core.restart_cnt - n0), 16'h0000);
      pulse(srcs[i]);
      for (k = 0; k < 10 && core.restart_cnt == n0; k++) @(posedge core_clk);
      #1 check(16'(core.restart_cnt - n0), 16'h0001);
      check(core.last_addr, 16'h0000);
      check(16'(reinit_cnt), 16'(i + 1));
      check(16'(regulator_off), 16'h0000);
      port_pins <= 8'hFF;
      rd(3'h1, wake_exp[i]);
      rd(3'h2, 8'h20);
    end
    // Reset in mid-run brings the power register back
    nrst <= 1'b0;
    cyc(2);
    nrst <= 1'b1;
    rd(3'h1, 8'h08);
    print_verdict();
  end
endmodule : power_mode_controller_tb_top
`default_nettype wire
